// *** src/microcode_fetch_sequencer.sv ***
// Summary of operation
// - prefetch register captures memory word only on the fetch load pulse
// - current register loads from prefetch register when advance fires
// - advance also fires cycle after status transfer if result bit 0 set
// - unfilled pipeline routes prefetch register straight to decode mux
// - translation uses current register later, always for right stack op
// - decode mux picks prefetch or current register for the mapper
// - mapper forms 8-bit table index from instruction bits and controls
// - table entry gives start address and eight control bits
// - three prefill bits say how many stack registers must be valid
// - table bit 0 is mode bit, latched when new instruction begins
// - stack op group stores mode one, no pre-adder effect
// - group 1 branch: bit 10 is displacement sign, add or subtract
// - group 1 shift: pre-adder outputs 6-bit shift count
// - group 2: pre-adder input bits 8:15, mode selects function
// - special op 00: mode zero, output is 4-bit constant field
// - special ops 01 to 17 behave like group 2
// - memory reference groups map to shared address routine, mode one
// - table jump without indirection uses mode-modified table index
// - address mux picks one of 9 sources, address plus one offered
// - microaddress register loads ROM address plus one each microcycle
// - repeat holds microaddress register unchanged
// - register also loads jump target, vectors, result bus, panel
// - ROM word captured into stage one, then moved to stage two
//
// The implementer's own choices: the address map and the address-and-strobe port.
`default_nettype none
module microcode_fetch_sequencer (
  input  wire logic                                clk,
  input  wire logic                                reset,
  input  wire logic [fetch_seq_pkg::INSTR_W-1:0]   mem_word,
  input  wire fetch_seq_pkg::fetch_ctl_type        fetch_ctl,
  input  wire logic [fetch_seq_pkg::INSTR_W-1:0]   result_bus,
  input  wire fetch_seq_pkg::micro_req_type        micro_req,
  input  wire logic [fetch_seq_pkg::UWORD_W-1:0]   rom_data,
  output logic      [fetch_seq_pkg::UADDR_W-1:0]   rom_addr,
  output logic      [fetch_seq_pkg::UADDR_W-1:0]   microaddr,
  output logic      [fetch_seq_pkg::UWORD_W-1:0]   micro_stage_one,
  output logic      [fetch_seq_pkg::UWORD_W-1:0]   micro_stage_two,
  output logic      [fetch_seq_pkg::INSTR_W-1:0]   prefetch_instr,
  output logic      [fetch_seq_pkg::INSTR_W-1:0]   current_instr,
  output var fetch_seq_pkg::lut_entry_type         lut_ctl,
  output logic                                     table_mode,
  output logic      [fetch_seq_pkg::INSTR_W-1:0]   preadder_out,
  output var fetch_seq_pkg::addr_src_type          addr_src,
  output logic                                     pipe_filled,
  output logic                                     microcycle_tick
);
  import fetch_seq_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DIV_W-1:0]   div_count;
    logic               tick;
    logic [INSTR_W-1:0] prefetch_instr_reg;
    logic [INSTR_W-1:0] current_instr_reg;
    logic               pipe_filled;
    logic               status_xfer_pending;
    logic               table_mode_reg;
    logic [UADDR_W-1:0] microaddr_reg;
    logic [UADDR_W-1:0] rom_addr_reg;
    logic [UWORD_W-1:0] stage_one_reg;
    logic [UWORD_W-1:0] stage_two_reg;
    lut_entry_type      lut_reg;
    logic [INSTR_W-1:0] preadder_reg;
    addr_src_type       src_reg;
  } seq_state_type;

  seq_state_type st_reg;
  seq_state_type st_next;

  // ---------------------------------------------------------------
  // decode path signals
  // ---------------------------------------------------------------
  logic                 tick;
  logic                 fetch_load_pulse;
  logic                 instr_advance;
  logic                 decode_from_prefetch;
  logic [INSTR_W-1:0]   decode_source_mux;
  logic [3:0]           opcode_group;
  logic                 table_jump_taken;
  logic                 table_modify;
  logic [MAP_IDX_W-1:0] map_index;
  lut_entry_type        lut_entry;
  logic [INSTR_W-1:0]   preadder_sum;
  addr_src_type         src_sel;
  logic [UADDR_W-1:0]   microaddr_mux;
  logic [UADDR_W-1:0]   jump_target;

  // microcycle enable comes one clock ahead of its use so the
  // registered strobe lines up with the sequencing edge
  assign tick = (st_reg.div_count == DIV_LAST);

  // ---------------------------------------------------------------
  // instruction register controls
  // ---------------------------------------------------------------
  assign fetch_load_pulse = tick & (fetch_ctl.next_skip | fetch_ctl.mcu_prefetch_opt);

  assign instr_advance = tick & (fetch_ctl.next_skip
                               | (st_reg.status_xfer_pending
                                  & result_bus[RESULT_BIT0]));

  // in the advance cycle the current register is not loaded yet, so the
  // prefetched word feeds the mapper directly and one microcycle is saved
  always_comb begin
    if (fetch_ctl.stack_right_op) begin
      decode_from_prefetch = 1'b0;
    end else if (instr_advance || !st_reg.pipe_filled) begin
      decode_from_prefetch = 1'b1;
    end else begin
      decode_from_prefetch = 1'b0;
    end
  end

  assign decode_source_mux = decode_from_prefetch ? st_reg.prefetch_instr_reg
                                                  : st_reg.current_instr_reg;
  assign opcode_group = decode_source_mux[GROUP_HI:GROUP_LO];

  // ---------------------------------------------------------------
  // mapper
  // ---------------------------------------------------------------
  assign table_jump_taken = micro_req.table_jump_op & ~micro_req.indirect_pending;
  // without the latched mode bit the table jump would land on the
  // shared address routine again and loop forever
  assign table_modify = table_jump_taken & st_reg.table_mode_reg;

  always_comb begin
    if (opcode_group == GROUP_STACK) begin
      map_index = fetch_ctl.stack_right_op
                ? {MAP_TAG_STACK, decode_source_mux[STACK_RIGHT_HI:STACK_RIGHT_LO]}
                : {MAP_TAG_STACK, decode_source_mux[STACK_LEFT_HI:STACK_LEFT_LO]};
    end else if (opcode_group <= GROUP_SPECIAL) begin
      map_index = {MAP_TAG_GROUP, opcode_group[1:0],
                   decode_source_mux[SPECIAL_OP_GROUP_HI:SPECIAL_OP_GROUP_LO]};
    end else begin
      map_index = {MAP_TAG_MEMREF, table_modify, 1'b0, opcode_group};
    end
  end

  instr_lookup_table u_lut (
    .index (map_index),
    .entry (lut_entry)
  );

  instr_preadder u_preadder (
    .instr (st_reg.current_instr_reg),
    .mode  (st_reg.table_mode_reg),
    .sum   (preadder_sum)
  );

  // ---------------------------------------------------------------
  // microaddress source selection
  // ---------------------------------------------------------------
  // fast jumps from stage one are left to the skip logic outside
  assign jump_target = {4'h0, st_reg.stage_two_reg[JUMP_TGT_W-1:0]};

  always_comb begin
    if (micro_req.powerfail_req) begin
      src_sel = SRC_POWERFAIL;
    end else if (micro_req.interrupt_req) begin
      src_sel = SRC_INTERRUPT;
    end else if (micro_req.jump_load_gate) begin
      src_sel = SRC_JUMP;
    end else if (micro_req.microaddr_store) begin
      src_sel = SRC_STORE;
    end else if (table_jump_taken) begin
      src_sel = SRC_TABLE;
    end else if (instr_advance) begin
      src_sel = SRC_START;
    end else if (micro_req.panel_load) begin
      src_sel = SRC_PANEL;
    end else if (micro_req.repeat_active) begin
      src_sel = SRC_REPEAT;
    end else begin
      src_sel = SRC_INCR;
    end
  end

  always_comb begin
    case (src_sel)
      SRC_POWERFAIL: microaddr_mux = micro_req.powerfail_vector;
      SRC_INTERRUPT: microaddr_mux = micro_req.interrupt_vector;
      SRC_JUMP:      microaddr_mux = jump_target;
      SRC_STORE:     microaddr_mux = result_bus;
      SRC_TABLE:     microaddr_mux = {5'h00, lut_entry.start_addr};
      SRC_START:     microaddr_mux = {5'h00, lut_entry.start_addr};
      SRC_PANEL:     microaddr_mux = micro_req.panel_addr;
      SRC_REPEAT:    microaddr_mux = st_reg.rom_addr_reg;
      SRC_INCR:      microaddr_mux = st_reg.microaddr_reg;
      default:       microaddr_mux = st_reg.microaddr_reg;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next      = st_reg;
    st_next.tick = tick;
    if (tick) begin
      st_next.div_count = '0;
    end else begin
      st_next.div_count = st_reg.div_count + 3'h1;
    end

    if (tick) begin
      if (fetch_load_pulse) begin
        st_next.prefetch_instr_reg = mem_word;
      end
      if (instr_advance) begin
        st_next.current_instr_reg = st_reg.prefetch_instr_reg;
        st_next.pipe_filled       = 1'b1;
        st_next.table_mode_reg    = lut_entry.mode;
      end
      // the status transfer only arms the advance for one microcycle
      st_next.status_xfer_pending = fetch_ctl.status_transfer_special;

      st_next.rom_addr_reg = microaddr_mux;
      if (src_sel != SRC_REPEAT) begin
        st_next.microaddr_reg = microaddr_mux + 16'h0001;
      end
      st_next.stage_one_reg = rom_data;
      st_next.stage_two_reg = st_reg.stage_one_reg;
      st_next.lut_reg       = lut_entry;
      st_next.preadder_reg  = preadder_sum;
      st_next.src_reg       = src_sel;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '{
        div_count:           '0,
        tick:                1'b0,
        prefetch_instr_reg:  '0,
        current_instr_reg:   '0,
        pipe_filled:         1'b0,
        status_xfer_pending: 1'b0,
        table_mode_reg:      1'b0,
        microaddr_reg:       '0,
        rom_addr_reg:        '0,
        stage_one_reg:       '0,
        stage_two_reg:       '0,
        lut_reg:             '0,
        preadder_reg:        '0,
        src_reg:             SRC_INCR
      };
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rom_addr        = st_reg.rom_addr_reg;
  assign microaddr       = st_reg.microaddr_reg;
  assign micro_stage_one = st_reg.stage_one_reg;
  assign micro_stage_two = st_reg.stage_two_reg;
  assign prefetch_instr  = st_reg.prefetch_instr_reg;
  assign current_instr   = st_reg.current_instr_reg;
  assign lut_ctl         = st_reg.lut_reg;
  assign table_mode      = st_reg.table_mode_reg;
  assign preadder_out    = st_reg.preadder_reg;
  assign addr_src        = st_reg.src_reg;
  assign pipe_filled     = st_reg.pipe_filled;
  assign microcycle_tick = st_reg.tick;

endmodule // microcode_fetch_sequencer
`default_nettype wire

// *** src/fetch_seq_pkg.sv ***
`default_nettype none
package fetch_seq_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int MICROCYCLE_NS   = 175;
  localparam int MICROCYCLE_CLKS = MICROCYCLE_NS / CLK_PERIOD_NS;
  localparam int DIV_W           = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MICROCYCLE_CLKS - 1);

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int INSTR_W     = 16;
  localparam int UADDR_W     = 16;
  localparam int UWORD_W     = 32;
  localparam int MAP_IDX_W   = 8;
  localparam int LUT_ADDR_W  = 11;
  localparam int PREFILL_W   = 3;
  localparam int JUMP_TGT_W  = 12;

  // ---------------------------------------------------------------
  // instruction fields (bit 0 of the word is the msb)
  // ---------------------------------------------------------------
  localparam int GROUP_HI        = 15;
  localparam int GROUP_LO        = 12;
  localparam int SPECIAL_OP_GROUP_HI       = 11;
  localparam int SPECIAL_OP_GROUP_LO       = 8;
  localparam int STACK_LEFT_HI   = 11;
  localparam int STACK_LEFT_LO   = 6;
  localparam int STACK_RIGHT_HI  = 5;
  localparam int STACK_RIGHT_LO  = 0;
  localparam int BRANCH_SIGN_BIT = 5;
  localparam int BRANCH_DISP_HI  = 4;
  localparam int SHIFT_CNT_HI    = 5;
  localparam int FIELD8_HI       = 7;
  localparam int KFIELD_HI       = 3;
  localparam int RESULT_BIT0     = 15;

  localparam logic [3:0] GROUP_STACK   = 4'h0;
  localparam logic [3:0] GROUP_ONE     = 4'h1;
  localparam logic [3:0] GROUP_TWO     = 4'h2;
  localparam logic [3:0] GROUP_SPECIAL = 4'h3;
  localparam logic [3:0] SPECIAL_OP_GROUP_ZERO   = 4'h0;

  // mapper index tags in index bits 7:6
  localparam logic [1:0] MAP_TAG_GROUP  = 2'h0;
  localparam logic [1:0] MAP_TAG_MEMREF = 2'h1;
  localparam logic [1:0] MAP_TAG_STACK  = 2'h2;

  localparam logic [PREFILL_W-1:0] PREFILL_STACK  = 3'h2;
  localparam logic [PREFILL_W-1:0] PREFILL_MEMREF = 3'h1;
  localparam logic [PREFILL_W-1:0] PREFILL_NONE   = 3'h0;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [LUT_ADDR_W-1:0] start_addr;
    logic                  mode;
    logic [PREFILL_W-1:0]  prefill;
    logic                  zero_ctl;
    logic                  preadder_ctl_a;
    logic                  preadder_ctl_b;
    logic                  table_jump_bit;
  } lut_entry_type;

  typedef struct packed {
    logic next_skip;
    logic mcu_prefetch_opt;
    logic status_transfer_special;
    logic stack_right_op;
  } fetch_ctl_type;

  typedef struct packed {
    logic               powerfail_req;
    logic               interrupt_req;
    logic               jump_load_gate;
    logic               microaddr_store;
    logic               table_jump_op;
    logic               indirect_pending;
    logic               panel_load;
    logic               repeat_active;
    logic [UADDR_W-1:0] interrupt_vector;
    logic [UADDR_W-1:0] powerfail_vector;
    logic [UADDR_W-1:0] panel_addr;
  } micro_req_type;

  typedef enum logic [3:0] {
    SRC_POWERFAIL, SRC_INTERRUPT, SRC_JUMP, SRC_STORE, SRC_TABLE,
    SRC_START, SRC_PANEL, SRC_REPEAT, SRC_INCR
  } addr_src_type;

endpackage
`default_nettype wire

// *** src/instr_lookup_table.sv ***
`default_nettype none
module instr_lookup_table (
  input  wire logic [fetch_seq_pkg::MAP_IDX_W-1:0] index,
  output var fetch_seq_pkg::lut_entry_type         entry
);
  import fetch_seq_pkg::*;

  logic [1:0] tag;
  logic [1:0] sub_group;
  logic [3:0] sub_field;

  always_comb begin
    tag       = index[7:6];
    sub_group = index[5:4];
    sub_field = index[3:0];
    entry                = '0;
    entry.start_addr     = {index, 3'h0};
    entry.preadder_ctl_a = (tag == MAP_TAG_MEMREF);
    entry.preadder_ctl_b = (tag == MAP_TAG_STACK);
    entry.prefill        = PREFILL_NONE;
    case (tag)
      MAP_TAG_STACK: begin
        entry.mode    = 1'b1;
        entry.prefill = PREFILL_STACK;
      end
      MAP_TAG_MEMREF: begin
        entry.mode           = 1'b1;
        entry.prefill        = PREFILL_MEMREF;
        entry.table_jump_bit = ~index[5];
      end
      default: begin
        case (sub_group)
          GROUP_ONE[1:0]:     entry.mode = ~sub_field[3];
          GROUP_TWO[1:0]:     entry.mode = sub_field[0];
          GROUP_SPECIAL[1:0]: entry.mode = (sub_field == SPECIAL_OP_GROUP_ZERO) ? 1'b0 : sub_field[0];
          default:            entry.mode = 1'b1;
        endcase
        entry.zero_ctl = (sub_group == GROUP_SPECIAL[1:0]) && (sub_field == SPECIAL_OP_GROUP_ZERO);
      end
    endcase
  end

endmodule // instr_lookup_table
`default_nettype wire

// *** src/instr_preadder.sv ***
`default_nettype none
module instr_preadder (
  input  wire logic [fetch_seq_pkg::INSTR_W-1:0] instr,
  input  wire logic                              mode,
  output logic      [fetch_seq_pkg::INSTR_W-1:0] sum
);
  import fetch_seq_pkg::*;

  logic [3:0]         group;
  logic [INSTR_W-1:0] field;

  always_comb begin
    group = instr[GROUP_HI:GROUP_LO];
    field = '0;
    sum   = '0;
    case (group)
      GROUP_STACK: sum = '0;
      GROUP_ONE: begin
        if (mode) begin
          field = {11'h000, instr[BRANCH_DISP_HI:0]};
          sum   = instr[BRANCH_SIGN_BIT] ? (16'h0000 - field) : field;
        end else begin
          sum = {10'h000, instr[SHIFT_CNT_HI:0]};
        end
      end
      GROUP_TWO: begin
        // no index operand: second input is zero
        field = {8'h00, instr[FIELD8_HI:0]};
        sum   = mode ? field : (16'h0000 - field);
      end
      GROUP_SPECIAL: begin
        if (instr[SPECIAL_OP_GROUP_HI:SPECIAL_OP_GROUP_LO] == SPECIAL_OP_GROUP_ZERO) begin
          sum = {12'h000, instr[KFIELD_HI:0]};
        end else begin
          field = {8'h00, instr[FIELD8_HI:0]};
          sum   = mode ? field : (16'h0000 - field);
        end
      end
      default: sum = {8'h00, instr[FIELD8_HI:0]};
    endcase
  end

endmodule // instr_preadder
`default_nettype wire

// *** tb/fetch_seq_checker_asserts.sv ***
`default_nettype none
module fetch_seq_checker (
  input wire logic                         clk,
  input wire logic                         reset,
  input wire logic [15:0]                  mem_word,
  input wire fetch_seq_pkg::fetch_ctl_type fetch_ctl,
  input wire logic [15:0]                  result_bus,
  input wire fetch_seq_pkg::micro_req_type micro_req,
  input wire logic [31:0]                  rom_data,
  input wire logic [15:0]                  rom_addr,
  input wire logic [15:0]                  microaddr,
  input wire logic [31:0]                  micro_stage_one,
  input wire logic [31:0]                  micro_stage_two,
  input wire logic [15:0]                  prefetch_instr,
  input wire logic [15:0]                  current_instr,
  input wire logic                         table_mode,
  input wire fetch_seq_pkg::addr_src_type  addr_src,
  input wire logic                         pipe_filled,
  input wire logic                         microcycle_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  import fetch_seq_pkg::*;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic t, ld, adv, hi, quiet, arm_reg;
  assign t = microcycle_tick;
  assign ld = fetch_ctl.next_skip | fetch_ctl.mcu_prefetch_opt;
  assign adv = fetch_ctl.next_skip | (arm_reg & result_bus[15]);
  assign hi = |{micro_req.powerfail_req, micro_req.interrupt_req, micro_req.jump_load_gate,
    micro_req.microaddr_store, micro_req.table_jump_op & ~micro_req.indirect_pending,
    micro_req.panel_load};
  assign quiet = ~hi & ~adv;
  // arm taken one clock late: requests stand over the whole microcycle
  always_ff @(posedge clk) begin
    if (reset) begin
      arm_reg <= 1'b0;
    end else if (t) begin
      arm_reg <= fetch_ctl.status_transfer_special;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  prefetch_hold_a : assert property (t && !$past(ld) |-> $stable(prefetch_instr))
    else $error("prefetch word changed without a load");
  prefetch_load_a : assert property (
    t && $past(ld) |-> prefetch_instr == $past(mem_word)) else $error("prefetch load wrong");
  instr_advance_a : assert property (
    t && $past(adv) |-> current_instr == $past(prefetch_instr) && pipe_filled)
    else $error("advance did not move the prefetch word");
  plus_one_a : assert property (t |-> microaddr == rom_addr + 16'h1)
    else $error("microaddress is not rom address plus one");
  seq_incr_a : assert property (
    t && $past(quiet && !micro_req.repeat_active) |-> rom_addr == $past(microaddr))
    else $error("sequence did not step");
  repeat_hold_a : assert property (
    t && $past(quiet && micro_req.repeat_active) |-> $stable(rom_addr) && $stable(microaddr))
    else $error("repeat did not hold the address");
  powerfail_a : assert property (
    t && $past(micro_req.powerfail_req) |-> rom_addr == $past(micro_req.powerfail_vector)
    && addr_src == SRC_POWERFAIL) else $error("power fail vector lost");
  jump_load_a : assert property (
    t && $past(micro_req.jump_load_gate & ~micro_req.powerfail_req & ~micro_req.interrupt_req)
    |-> rom_addr == {4'h0, $past(micro_stage_two[11:0])}) else $error("jump target wrong");
  stage_pipe_a : assert property (
    t |-> micro_stage_one == $past(rom_data) && micro_stage_two == $past(micro_stage_one))
    else $error("output stages did not shift");
  tick_period_a : assert property (t |=> !t [*6] ##1 t)
    else $error("microcycle is not seven clocks");
  reset_clear_a : assert property (
    $fell(reset) |-> rom_addr == 16'h0 && microaddr == 16'h0 && current_instr == 16'h0
    && prefetch_instr == 16'h0 && !table_mode && !pipe_filled) else $error("reset state wrong");
  cover property (t && $past(adv));
  cover property (t && $past(quiet && micro_req.repeat_active));
  cover property (t && $past(micro_req.jump_load_gate));
endmodule // fetch_seq_checker

bind microcode_fetch_sequencer fetch_seq_checker checker_i (.clk, .reset, .mem_word,
  .fetch_ctl, .result_bus, .micro_req, .rom_data, .rom_addr, .microaddr, .micro_stage_one,
  .micro_stage_two, .prefetch_instr, .current_instr, .table_mode, .addr_src, .pipe_filled,
  .microcycle_tick);
`default_nettype wire

// *** tb/mem_unit_model.sv ***
`default_nettype none
module mem_unit_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        tick,
  input  wire logic [15:0] word,
  input  wire logic [2:0]  lag,
  output logic      [15:0] mem_word
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // slow memory: word valid lag clocks into the microcycle
  // ---------------------------------------------------------------
  logic [2:0] age_reg;
  always_ff @(posedge clk) begin
    if (reset || tick) begin
      age_reg <= 3'h0;
    end else if (age_reg != 3'h7) begin
      age_reg <= age_reg + 3'h1;
    end
  end
  // inverse until valid, so an early sample cannot match by chance
  assign mem_word = (age_reg >= lag) ? word : ~word;
endmodule // mem_unit_model
`default_nettype wire

// *** tb/tb_top.sv ***
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import fetch_seq_pkg::*;
  localparam logic [3:0] NS = 4'h8;
  localparam logic [3:0] OPT = 4'h4;
  localparam logic [3:0] STS = 4'h2;
  logic          clk = 1'b0;
  logic          reset = 1'b1;
  fetch_ctl_type fc = '0;
  micro_req_type mr = '0;
  micro_req_type m;
  logic [15:0]   rb = 16'h0, b = 16'h0, word = 16'h0, mem_word, rom_addr, microaddr;
  logic [15:0]   prefetch_instr, current_instr, preadder_out;
  logic [31:0]   rd = 32'h0, d = 32'h0, micro_stage_one, micro_stage_two;
  logic [2:0]    lag = 3'h0;
  logic          table_mode, pipe_filled, microcycle_tick;
  lut_entry_type lut_ctl;
  addr_src_type  addr_src;
  int            mismatches = 0, checks = 0, cycles = 0;

  always #12.5 clk = ~clk;
  microcode_fetch_sequencer dut (.clk, .reset, .mem_word, .fetch_ctl(fc), .result_bus(rb),
    .micro_req(mr), .rom_data(rd), .rom_addr, .microaddr, .micro_stage_one, .micro_stage_two,
    .prefetch_instr, .current_instr, .lut_ctl, .table_mode, .preadder_out, .addr_src,
    .pipe_filled, .microcycle_tick);
  mem_unit_model mem_unit (.clk, .reset, .tick(microcycle_tick), .word, .lag, .mem_word);
  // ---------------------------------------------------------------
  // common tasks
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1500) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // requests stand a whole microcycle, outputs judged once settled
  task automatic mc(logic [3:0] f, logic [15:0] w);
    @(posedge clk);
    fc <= fetch_ctl_type'(f);
    mr <= m;
    word <= w;
    rb <= b;
    rd <= d;
    for (int i = 0; i < 9; i++) begin
      @(negedge clk);
      if (microcycle_tick) break;
    end
    chk("tick", microcycle_tick, 1'b1);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_fetch();
    m = '0;
    lag <= 3'h5;
    chk("fill", pipe_filled, 1'b0);
    mc(OPT, 16'h0a95);
    chk("pre", prefetch_instr, 16'h0a95);
    mc(4'h0, 16'h4000);
    chk("pre", prefetch_instr, 16'h0a95);
    chk("cur", current_instr, 16'h0);
    chk("lut", lut_ctl.start_addr, 11'h550);
    mc(NS, 16'h4000);
    chk("cur", current_instr, 16'h0a95);
    chk("pre", prefetch_instr, 16'h4000);
    chk("fill", pipe_filled, 1'b1);
    chk("rom", rom_addr, 16'h0550);
    chk("mode", table_mode, 1'b1);
    chk("prefill", lut_ctl.prefill, PREFILL_STACK);
    mc(4'h1, 16'h4000);
    chk("lut", lut_ctl.start_addr, 11'h4a8);
    mc(4'h0, 16'h4000);
    chk("lut", lut_ctl.start_addr, 11'h550);
    $display("fetch test done");
  endtask
  task automatic t_status();
    b = 16'h0;
    mc(STS, 16'h4000);
    b = 16'h7fff;
    mc(4'h0, 16'h4000);
    chk("cur", current_instr, 16'h0a95);
    mc(STS, 16'h4000);
    b = 16'h8000;
    mc(4'h0, 16'h4000);
    chk("cur", current_instr, 16'h4000);
    chk("rom", rom_addr, 16'h0220);
    chk("mode", table_mode, 1'b1);
    $display("status test done");
  endtask
  task automatic t_seq();
    d = 32'h1111_0001;
    mc(4'h0, 16'h4000);
    chk("rom", rom_addr, 16'h0221);
    chk("one", micro_stage_one, 32'h1111_0001);
    m.repeat_active = 1'b1;
    mc(4'h0, 16'h4000);
    chk("rom", rom_addr, 16'h0221);
    chk("two", micro_stage_two, 32'h1111_0001);
    m = '0;
    m.table_jump_op = 1'b1;
    m.indirect_pending = 1'b1;
    mc(4'h0, 16'h4000);
    chk("rom", rom_addr, 16'h0222);
    m.indirect_pending = 1'b0;
    mc(4'h0, 16'h4000);
    chk("rom", rom_addr, 16'h0320);
    m = '0;
    $display("sequence test done");
  endtask
  task automatic t_prio();
    logic [15:0] exp [5] = '{16'h1234, 16'h2345, 16'h07de, 16'h3456, 16'h4567};
    addr_src_type src [5] = '{SRC_POWERFAIL, SRC_INTERRUPT, SRC_JUMP, SRC_STORE, SRC_PANEL};
    d = 32'h89ab_c7de;
    b = 16'h3456;
    mc(4'h0, 16'h4000);
    mc(4'h0, 16'h4000);
    m.powerfail_vector = 16'h1234;
    m.interrupt_vector = 16'h2345;
    m.panel_addr = 16'h4567;
    m.panel_load = 1'b1;
    m.repeat_active = 1'b1;
    for (int k = 0; k < 5; k++) begin
      m.powerfail_req = (k == 0);
      m.interrupt_req = (k <= 1);
      m.jump_load_gate = (k <= 2);
      m.microaddr_store = (k <= 3);
      mc(4'h0, 16'h4000);
      chk("rom", rom_addr, exp[k]);
      chk("src", addr_src, src[k]);
    end
    m = '0;
    $display("priority test done");
  endtask
  task automatic t_pre();
    logic [15:0] w [8] = '{16'h0a95, 16'h102c, 16'h100c, 16'h1825, 16'h2134, 16'h2034,
      16'h30a7, 16'h3155};
    logic [15:0] p [8] = '{16'h0000, 16'hfff4, 16'h000c, 16'h0025, 16'h0034, 16'hffcc,
      16'h0007, 16'h0055};
    logic [7:0] md = 8'h97;
    lag <= 3'h0;
    for (int i = 0; i < 8; i++) begin
      mc(OPT, w[i]);
      mc(NS, w[i]);
      mc(4'h0, w[i]);
      chk("mode", table_mode, md[i]);
      chk("sum", preadder_out, p[i]);
      chk("zero", lut_ctl.zero_ctl, i == 6);
    end
    $display("pre-adder test done");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    t_fetch();
    t_status();
    t_seq();
    t_prio();
    t_pre();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
